// ==== verilog/ocf_pkg.sv ====
package ocf_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int OCF_FILTER_W = 38;                  // filter register width
    localparam int OCF_COUNT_W  = 48;                  // event counter width

    // ------------------------------------------------------------
    // filter register layout
    // ------------------------------------------------------------
    localparam int OCF_BIT_ANY  = 16;                  // catch-all response bit
    localparam int OCF_BIT_R30  = 30;                  // reserved, reads zero
    localparam logic [37:0] OCF_REQ_FIELD  = 38'h00_0000_FFFF; // bits 15:0
    localparam logic [37:0] OCF_SUP_FIELD  = 38'h00_3FFE_0000; // bits 29:17
    localparam logic [37:0] OCF_SNP_FIELD  = 38'h3F_8000_0000; // bits 37:31
    localparam logic [37:0] OCF_WR_BASE    = 38'h3F_BC3F_85B7; // always writable
    localparam logic [37:0] OCF_WR_PMEM    = 38'h00_03C0_0000; // bits 25:22
    localparam logic [37:0] OCF_FILTER_RST = 38'h00_0000_0000; // filter reset
    localparam logic [47:0] OCF_COUNT_RST  = 48'h0000_0000_0000; // counter reset
    localparam logic [47:0] OCF_COUNT_ONE  = 48'h0000_0000_0001; // increment
    localparam logic [47:0] OCF_COUNT_MAX  = 48'hFFFF_FFFF_FFFF; // wrap point

    // ------------------------------------------------------------
    // transaction classes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        REQ_DEMAND_LOAD = 4'h0, REQ_DEMAND_OWN = 4'h1, REQ_DEMAND_CODE = 4'h2,
        REQ_MID_PF_LOAD = 4'h3, REQ_MID_PF_OWN = 4'h4, REQ_LAST_PF_LOAD = 4'h5,
        REQ_LAST_PF_OWN = 4'h6, REQ_FIRST_SW_PF = 4'h7, REQ_OTHER = 4'h8
    } ocf_req_e;

    typedef enum logic [3:0] {
        SUP_NONE = 4'h0, SUP_HIT_MOD = 4'h1, SUP_HIT_EXCL = 4'h2,
        SUP_HIT_SHARED = 4'h3, SUP_HIT_FWD = 4'h4, SUP_PMEM_LOCAL = 4'h5,
        SUP_PMEM_HOP0 = 4'h6, SUP_PMEM_HOP1 = 4'h7, SUP_PMEM_FAR = 4'h8,
        SUP_DRAM_LOCAL = 4'h9, SUP_DRAM_HOP0 = 4'hA, SUP_DRAM_HOP1 = 4'hB,
        SUP_DRAM_FAR = 4'hC
    } ocf_sup_e;

    typedef enum logic [2:0] {
        SNP_NONE = 3'h0, SNP_NOT_NEEDED = 3'h1, SNP_MISS = 3'h2,
        SNP_HIT_NO_FWD = 3'h3, SNP_HIT_FWD = 3'h4, SNP_HIT_MOD = 3'h5,
        SNP_NON_DRAM = 3'h6
    } ocf_snp_e;

    // bit position of each class, indexed by its code
    // request positions
    localparam int OCF_REQ_POS [9]  = '{0, 1, 2, 4, 5, 7, 8, 10, 15};
    // supplier positions snoop positions
    localparam int OCF_SUP_POS [13] = '{17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27, 28, 29};
    localparam int OCF_SNP_POS [7]  = '{31, 32, 33, 34, 35, 36, 37};
    localparam int OCF_REQ_N = 9;                      // request classes
    localparam int OCF_SUP_N = 13;                     // supplier classes
    localparam int OCF_SNP_N = 7;                      // snoop classes

    // one off-core transaction as reported by the memory pipeline
    typedef struct packed {
        ocf_req_e req;                                 // request type
        ocf_sup_e sup;                                 // who supplied the data
        ocf_snp_e snp;                                 // snoop outcome
    } ocf_txn_s;

    // ------------------------------------------------------------
    // decode: the filter bits that a transaction stands for
    // ------------------------------------------------------------
    function automatic logic [37:0] ocf_txn_bits(input ocf_txn_s t);
        logic [37:0] v;
        v = OCF_FILTER_RST;
        if (int'(t.req) < OCF_REQ_N) v[OCF_REQ_POS[int'(t.req)]] = 1'b1;
        if (int'(t.sup) < OCF_SUP_N) v[OCF_SUP_POS[int'(t.sup)]] = 1'b1;
        if (int'(t.snp) < OCF_SNP_N) v[OCF_SNP_POS[int'(t.snp)]] = 1'b1;
        return v;
    endfunction

    // request matches a set type bit and response a set response bit
    function automatic logic ocf_filter_hit(input logic [37:0] sel, input ocf_txn_s t);
        logic [37:0] b;
        logic        req_ok;
        logic        sup_ok;
        logic        snp_ok;
        b      = ocf_txn_bits(t);
        req_ok = |(sel & b & OCF_REQ_FIELD);
        // an empty sub-field leaves that side of the response open
        sup_ok = ((sel & OCF_SUP_FIELD) == OCF_FILTER_RST) || |(sel & b & OCF_SUP_FIELD);
        snp_ok = ((sel & OCF_SNP_FIELD) == OCF_FILTER_RST) || |(sel & b & OCF_SNP_FIELD);
        return req_ok && (sel[OCF_BIT_ANY]
               || (((sel & (OCF_SUP_FIELD | OCF_SNP_FIELD)) != OCF_FILTER_RST) && sup_ok && snp_ok));
    endfunction

endpackage

// ==== verilog/ocf_match.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// registered match stage
// ------------------------------------------------------------
module ocf_match
    import ocf_pkg::*;
(
    input  wire logic        mclk_i,      // core clock
    input  wire logic        rst_i,       // sync reset, high
    input  wire logic [37:0] sel_i,       // filter selection
    input  wire logic        txn_valid_i, // transaction strobe
    input  wire ocf_txn_s    txn_i,       // transaction class
    output logic             hit_o        // one-cycle match pulse
);

    // all state in one struct
    typedef struct packed {
        logic hit;                        // match seen last cycle
    } ocf_match_state_s;

    ocf_match_state_s s_q;                // registered state
    ocf_match_state_s s_d;                // next state

    // match decode; registered so the long and-or tree has a full cycle
    always_comb begin
        s_d     = s_q;
        s_d.hit = txn_valid_i && ocf_filter_hit(sel_i, txn_i);
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hit_o = s_q.hit;

endmodule // ocf_match

// ==== verilog/ocf_filter.sv ====
`timescale 1ns/1ns

// ------------------------------------------------------------
// off-core response filter and counter
// ------------------------------------------------------------
module ocf_filter
    import ocf_pkg::*;
(
    input  wire logic        mclk_i,          // core clock, 10 MHz
    input  wire logic        rst_i,           // sync reset, high
    input  wire logic        pmem_strap_i,    // part has persistent memory
    input  wire logic        filter_wr_i,     // filter register write
    input  wire logic [37:0] filter_wdata_i,  // filter write data
    input  wire logic        count_wr_i,      // counter load
    input  wire logic [47:0] count_wdata_i,   // counter load value
    input  wire logic        ovf_clr_i,       // overflow flag clear
    input  wire logic        txn_valid_i,     // transaction strobe
    input  wire ocf_txn_s    txn_i,           // transaction class
    output logic      [37:0] filter_rd_o,     // filter read back
    output logic      [47:0] count_o,         // event count
    output logic             ovf_o,           // sticky wrap flag
    output logic             match_o,         // one-cycle count pulse
    output logic             pmem_mode_o      // persistent layout active
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [37:0] filter;                  // filter register
        logic [47:0] count;                   // event counter
        logic        ovf;                     // counter wrapped
        logic        match;                   // counted this cycle
        logic        pmem;                    // captured strap
    } ocf_state_s;

    ocf_state_s s_q;                          // registered state
    ocf_state_s s_d;                          // next state
    logic       hit;                          // from match stage
    logic [37:0] wr_mask;                     // writable bits now

    // ------------------------------------------------------------
    // match stage
    // ------------------------------------------------------------
    // sees the filter as it stands, so a write in the same cycle
    // as a transaction only affects later transactions
    ocf_match u_match (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .sel_i       (s_q.filter),
        .txn_valid_i (txn_valid_i),
        .txn_i       (txn_i),
        .hit_o       (hit)
    );

    // writable bits: the persistent-memory supplier bits exist only
    // on parts with that support, elsewhere they stay reserved
    always_comb begin
        wr_mask = OCF_WR_BASE;
        if (s_q.pmem) begin
            wr_mask = OCF_WR_BASE | OCF_WR_PMEM;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.match = hit;
        // reserved bits never store, so they read zero even when
        // software ignores them; bit 30 included
        if (filter_wr_i) begin
            s_d.filter = filter_wdata_i & wr_mask;
        end
        // a load wins over an increment in the same cycle
        if (count_wr_i) begin
            s_d.count = count_wdata_i;
        end else if (hit) begin
            s_d.count = s_q.count + OCF_COUNT_ONE;
        end
        // overflow: the set wins over a clear in the same cycle
        if (ovf_clr_i) begin
            s_d.ovf = 1'b0;
        end
        if (!count_wr_i && hit && (s_q.count == OCF_COUNT_MAX)) begin
            s_d.ovf = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // the strap is sampled all through reset and frozen at release
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_q        <= '0;
            s_q.filter <= OCF_FILTER_RST;
            s_q.count  <= OCF_COUNT_RST;
            s_q.pmem   <= pmem_strap_i;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign filter_rd_o = s_q.filter;
    assign count_o     = s_q.count;
    assign ovf_o       = s_q.ovf;
    assign match_o     = s_q.match;
    assign pmem_mode_o = s_q.pmem;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a transaction at cycle t shows in count_o at t+2
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // request field stores exactly the writable request bits
    property p_req_field;
        filter_wr_i |=> (filter_rd_o & OCF_REQ_FIELD) == ($past(filter_wdata_i) & OCF_WR_BASE & OCF_REQ_FIELD);
    endproperty
    a_req_field: assert property (p_req_field) else $error("request field store wrong");

    // supplier field stores, persistent bits only with the strap
    property p_sup_field;
        filter_wr_i |=> filter_rd_o[29:16] == ($past(filter_wdata_i[29:16]) & $past(wr_mask[29:16]));
    endproperty
    a_sup_field: assert property (p_sup_field) else $error("supplier field store wrong");

    // snoop field stores bits 37:31, reserved bit 30 stays clear
    property p_snp_field;
        filter_wr_i |=> (filter_rd_o[37:31] == $past(filter_wdata_i[37:31])) && !filter_rd_o[OCF_BIT_R30];
    endproperty
    a_snp_field: assert property (p_snp_field) else $error("snoop field store wrong");

    // demand data read counts with its bit and the catch-all
    property p_demand_load;
        (txn_valid_i && txn_i.req == REQ_DEMAND_LOAD && filter_rd_o[OCF_REQ_POS[0]]
         && filter_rd_o[OCF_BIT_ANY]) ##1 !count_wr_i |=> count_o == $past(count_o) + OCF_COUNT_ONE;
    endproperty
    a_demand_load: assert property (p_demand_load) else $error("demand load not counted");

    // demand ownership counts, match pulse two cycles later
    property p_demand_own;
        (txn_valid_i && txn_i.req == REQ_DEMAND_OWN && filter_rd_o[OCF_REQ_POS[1]]
         && filter_rd_o[OCF_BIT_ANY]) |-> ##2 match_o;
    endproperty
    a_demand_own: assert property (p_demand_own) else $error("demand ownership missed");

    // code read selected by bit 2 only
    property p_demand_code;
        (txn_valid_i && txn_i.req == REQ_DEMAND_CODE && !filter_rd_o[OCF_REQ_POS[2]]) |-> ##2 !match_o;
    endproperty
    a_demand_code: assert property (p_demand_code) else $error("code read counted unselected");

    // mid cache prefetch load
    property p_mid_pf;
        (txn_valid_i && txn_i.req == REQ_MID_PF_LOAD && filter_rd_o[OCF_REQ_POS[3]]
         && filter_rd_o[OCF_BIT_ANY]) |-> ##2 match_o;
    endproperty
    a_mid_pf: assert property (p_mid_pf) else $error("mid prefetch missed");

    // last cache prefetch ownership
    property p_last_pf;
        (txn_valid_i && txn_i.req == REQ_LAST_PF_OWN && filter_rd_o[OCF_REQ_POS[6]]
         && filter_rd_o[OCF_BIT_ANY]) |-> ##2 match_o;
    endproperty
    a_last_pf: assert property (p_last_pf) else $error("last prefetch missed");

    // first data or software prefetch
    property p_first_pf;
        (txn_valid_i && txn_i.req == REQ_FIRST_SW_PF && filter_rd_o[OCF_REQ_POS[7]]
         && filter_rd_o[OCF_BIT_ANY]) |-> ##2 match_o;
    endproperty
    a_first_pf: assert property (p_first_pf) else $error("first data prefetch missed");

    // miscellaneous requests
    property p_other;
        (txn_valid_i && txn_i.req == REQ_OTHER && filter_rd_o[OCF_REQ_POS[8]]
         && filter_rd_o[OCF_BIT_ANY]) |-> ##2 match_o;
    endproperty
    a_other: assert property (p_other) else $error("other request missed");

    // catch-all matches whatever the supplier and snoop
    property p_any;
        (txn_valid_i && |(filter_rd_o & OCF_REQ_FIELD & ocf_txn_bits(txn_i))
         && filter_rd_o[OCF_BIT_ANY]) |-> ##2 match_o;
    endproperty
    a_any: assert property (p_any) else $error("catch-all response missed");

    // no supplier information, snoop side left open
    property p_sup_none;
        (txn_valid_i && |(filter_rd_o & OCF_REQ_FIELD & ocf_txn_bits(txn_i)) && txn_i.sup == SUP_NONE
         && filter_rd_o[OCF_SUP_POS[0]] && (filter_rd_o & OCF_SNP_FIELD) == OCF_FILTER_RST) |-> ##2 match_o;
    endproperty
    a_sup_none: assert property (p_sup_none) else $error("no-supplier match missed");

    // last cache hit in modified state
    property p_hit_mod;
        (txn_valid_i && |(filter_rd_o & OCF_REQ_FIELD & ocf_txn_bits(txn_i)) && txn_i.sup == SUP_HIT_MOD
         && filter_rd_o[OCF_SUP_POS[1]] && (filter_rd_o & OCF_SNP_FIELD) == OCF_FILTER_RST) |-> ##2 match_o;
    endproperty
    a_hit_mod: assert property (p_hit_mod) else $error("modified hit missed");

    // supplier filter set but transaction from local dram not selected
    property p_dram_local;
        (txn_valid_i && txn_i.sup == SUP_DRAM_LOCAL && !filter_rd_o[OCF_SUP_POS[9]]
         && (filter_rd_o & OCF_SUP_FIELD) != OCF_FILTER_RST && !filter_rd_o[OCF_BIT_ANY]) |-> ##2 !match_o;
    endproperty
    a_dram_local: assert property (p_dram_local) else $error("local dram matched unselected");

    // remote dram hop zero
    property p_dram_hop0;
        (txn_valid_i && |(filter_rd_o & OCF_REQ_FIELD & ocf_txn_bits(txn_i)) && txn_i.sup == SUP_DRAM_HOP0
         && filter_rd_o[OCF_SUP_POS[10]] && (filter_rd_o & OCF_SNP_FIELD) == OCF_FILTER_RST) |-> ##2 match_o;
    endproperty
    a_dram_hop0: assert property (p_dram_hop0) else $error("remote dram hop0 missed");

    // persistent supplier bits never hold without the strap
    property p_pmem;
        !pmem_mode_o |-> (filter_rd_o & OCF_WR_PMEM) == OCF_FILTER_RST;
    endproperty
    a_pmem: assert property (p_pmem) else $error("persistent bits stored without support");

    // no request bit hit means no count
    property p_need_req;
        (txn_valid_i && !(|(filter_rd_o & OCF_REQ_FIELD & ocf_txn_bits(txn_i)))) |-> ##2 !match_o;
    endproperty
    a_need_req: assert property (p_need_req) else $error("counted without request hit");

    // no response bit set means no count
    property p_need_rsp;
        (txn_valid_i && (filter_rd_o & ~OCF_REQ_FIELD) == OCF_FILTER_RST) |-> ##2 !match_o;
    endproperty
    a_need_rsp: assert property (p_need_rsp) else $error("counted without response bit");

    // snoop miss selected, supplier side open
    property p_snp_miss;
        (txn_valid_i && |(filter_rd_o & OCF_REQ_FIELD & ocf_txn_bits(txn_i)) && txn_i.snp == SNP_MISS
         && filter_rd_o[OCF_SNP_POS[2]] && (filter_rd_o & OCF_SUP_FIELD) == OCF_FILTER_RST) |-> ##2 match_o;
    endproperty
    a_snp_miss: assert property (p_snp_miss) else $error("snoop miss not counted");

    // wrap sets the flag even against a clear
    property p_ovf;
        (match_o && $past(count_o) == OCF_COUNT_MAX && !$past(count_wr_i)) |-> ovf_o && count_o == OCF_COUNT_RST;
    endproperty
    a_ovf: assert property (p_ovf) else $error("wrap not flagged");

    // main scenarios
    c_count: cover property (txn_valid_i ##2 match_o);
    c_wrap: cover property ($rose(ovf_o));
    c_pmem: cover property (txn_valid_i && txn_i.sup == SUP_PMEM_LOCAL && pmem_mode_o ##2 match_o);

endmodule // ocf_filter

// ==== verif/ocf_filter_tb.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// self-checking bench for the off-core response filter
// ------------------------------------------------------------
module ocf_filter_tb;
    import ocf_pkg::*;

    localparam logic [37:0] ONE = 38'h00_0000_0001;      // single filter bit
    localparam int          CEILING = 2000;              // cycles before giving up

    logic        mclk_i;                                 // core clock
    logic        rst_i;                                  // sync reset
    logic        pmem_strap_i;                           // persistent memory strap
    logic        filter_wr_i;                            // filter write strobe
    logic [37:0] filter_wdata_i;                         // filter write data
    logic        count_wr_i;                             // counter load strobe
    logic [47:0] count_wdata_i;                          // counter load value
    logic        ovf_clr_i;                              // overflow clear
    logic        txn_valid_i;                            // transaction strobe
    ocf_txn_s    txn_i;                                  // transaction class
    logic [37:0] filter_rd_o;                            // filter read back
    logic [47:0] count_o;                                // event count
    logic        ovf_o;                                  // wrap flag
    logic        match_o;                                // count pulse
    logic        pmem_mode_o;                            // captured strap
    int          miscompares;                            // mismatches seen
    int          num_checks;                             // comparisons made
    int          cycles;                                 // timeout counter
    logic [47:0] exp_cnt;                                // expected count
    logic        pm;                                     // expected layout

    ocf_filter uut (
        .mclk_i(mclk_i), .rst_i(rst_i), .pmem_strap_i(pmem_strap_i),
        .filter_wr_i(filter_wr_i), .filter_wdata_i(filter_wdata_i),
        .count_wr_i(count_wr_i), .count_wdata_i(count_wdata_i), .ovf_clr_i(ovf_clr_i),
        .txn_valid_i(txn_valid_i), .txn_i(txn_i), .filter_rd_o(filter_rd_o),
        .count_o(count_o), .ovf_o(ovf_o), .match_o(match_o), .pmem_mode_o(pmem_mode_o)
    );

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    always #50 mclk_i = ~mclk_i;

    // a stuck run is counted as a mismatch and still ends in the report
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == CEILING) begin
            miscompares++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // inputs always move a fixed 10 ns after the rising edge
    task automatic tick;
        @(posedge mclk_i);
        #10;
    endtask

    task automatic do_reset(input logic strap);
        rst_i = 1'b1;
        pmem_strap_i = strap;
        repeat (12) tick();
        rst_i = 1'b0;
        pm = strap;
        exp_cnt = 48'h0000_0000_0000;
        tick();
        check("filter_rd", {10'h000, filter_rd_o}, 48'h0000_0000_0000);
        check("count", count_o, exp_cnt);
        check("ovf", {47'h0, ovf_o}, 48'h0000_0000_0000);
        check("pmem_mode", {47'h0, pmem_mode_o}, {47'h0, strap});
    endtask

    // reserved bits never store, the persistent bits only in that layout
    task automatic wr_filter(input logic [37:0] w);
        filter_wr_i = 1'b1;
        filter_wdata_i = w;
        tick();
        filter_wr_i = 1'b0;
        check("filter_rd", {10'h000, filter_rd_o},
              {10'h000, w & (OCF_WR_BASE | (pm ? OCF_WR_PMEM : OCF_FILTER_RST))});
    endtask

    // answer lands one edge after the taking edge and lasts one cycle
    task automatic do_txn(input ocf_req_e r, input ocf_sup_e s, input ocf_snp_e n, input logic hit);
        txn_i = '{req: r, sup: s, snp: n};
        txn_valid_i = 1'b1;
        tick();
        txn_valid_i = 1'b0;
        tick();
        if (hit) exp_cnt = exp_cnt + 48'h0000_0000_0001;
        check("match", {47'h0, match_o}, {47'h0, hit});
        check("count", count_o, exp_cnt);
        tick();
        check("match_end", {47'h0, match_o}, 48'h0000_0000_0000);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // each request class alone plus the catch-all; the neighbour class must not count
    task automatic t_requests;
        for (int i = 0; i < 9; i++) begin
            wr_filter((ONE << OCF_REQ_POS[i]) | (ONE << 16));
            do_txn(ocf_req_e'(4'(i)), SUP_NONE, SNP_NONE, 1'b1);
            do_txn(ocf_req_e'(4'((i + 1) % 9)), SUP_NONE, SNP_NONE, 1'b0);
        end
    endtask

    // persistent suppliers only match when that layout is strapped
    task automatic t_suppliers;
        for (int i = 0; i < 13; i++) begin
            wr_filter(ONE | (ONE << OCF_SUP_POS[i]));
            do_txn(REQ_DEMAND_LOAD, ocf_sup_e'(4'(i)), SNP_NONE, pm || i < 5 || i > 8);
            do_txn(REQ_DEMAND_LOAD, ocf_sup_e'(4'((i + 1) % 13)), SNP_NONE, 1'b0);
        end
    endtask

    task automatic t_snoops;
        for (int i = 0; i < 7; i++) begin
            wr_filter(ONE | (ONE << OCF_SNP_POS[i]));
            do_txn(REQ_DEMAND_LOAD, SUP_NONE, ocf_snp_e'(3'(i)), 1'b1);
            do_txn(REQ_DEMAND_LOAD, SUP_NONE, ocf_snp_e'(3'((i + 1) % 7)), 1'b0);
        end
    endtask

    // a request bit or a response bit alone is not enough
    task automatic t_need_both;
        wr_filter(ONE);
        do_txn(REQ_DEMAND_LOAD, SUP_NONE, SNP_NONE, 1'b0);
        wr_filter(ONE << 16);
        do_txn(REQ_DEMAND_LOAD, SUP_NONE, SNP_NONE, 1'b0);
        wr_filter(ONE | (ONE << 16));
        do_txn(ocf_req_e'(4'hF), SUP_NONE, SNP_NONE, 1'b0);
        do_txn(REQ_DEMAND_LOAD, SUP_NONE, SNP_NONE, 1'b1);
    endtask

    // counter loaded at all ones wraps on the next match and flags it
    task automatic t_wrap;
        count_wr_i = 1'b1;
        count_wdata_i = OCF_COUNT_MAX;
        tick();
        count_wr_i = 1'b0;
        exp_cnt = OCF_COUNT_MAX;
        check("count_load", count_o, exp_cnt);
        do_txn(REQ_DEMAND_LOAD, SUP_HIT_MOD, SNP_MISS, 1'b1);
        check("ovf_set", {47'h0, ovf_o}, 48'h0000_0000_0001);
        ovf_clr_i = 1'b1;
        tick();
        ovf_clr_i = 1'b0;
        check("ovf_clr", {47'h0, ovf_o}, 48'h0000_0000_0000);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        rst_i = 1'b1;
        pmem_strap_i = 1'b0;
        filter_wr_i = 1'b0;
        filter_wdata_i = 38'h00_0000_0000;
        count_wr_i = 1'b0;
        count_wdata_i = 48'h0000_0000_0000;
        ovf_clr_i = 1'b0;
        txn_valid_i = 1'b0;
        txn_i = '{req: REQ_DEMAND_LOAD, sup: SUP_NONE, snp: SNP_NONE};
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        do_reset(1'b0);
        wr_filter(38'h3F_FFFF_FFFF);
        t_requests();
        t_suppliers();
        t_snoops();
        t_need_both();
        t_wrap();
        do_reset(1'b1);
        wr_filter(38'h3F_FFFF_FFFF);
        t_suppliers();
        summarize();
    end
endmodule // ocf_filter_tb
